// ==== bench/installer_model.sv ====
`timescale 1ns/100ps
module installer_model (
  input wire logic clk,
  input wire volsense_pkg::switch_type sw_cmd,
  input wire logic [15:0] press,
  input wire logic fault_cmd,
  input wire logic [15:0] raw,
  output volsense_pkg::switch_type switches = 4'h0,
  output logic [15:0] cell_pressure = 16'h0,
  output logic cell_valid = 1'b0,
  output logic cell_fault = 1'b0,
  output logic [15:0] sash_raw = 16'h0,
  output logic sash_valid = 1'b0
);
  logic [3:0] tick = 4'h0;
  always_ff @(posedge clk) begin
    tick <= tick + 4'h1;
    // Switches as commanded, fault passes at once
    switches <= sw_cmd;
    cell_fault <= fault_cmd;
    // Data outside its strobe is inverted so stale values never match
    cell_valid <= tick[1:0] == 2'h3;
    cell_pressure <= (tick[1:0] == 2'h3) ? press : ~press;
    // Sash strobed once in 16 cycles, inverted in between like the cell data
    sash_valid <= tick == 4'hF;
    sash_raw <= (tick == 4'hF) ? raw : ~raw;
  end
endmodule : installer_model

// ==== bench/volsense_chk.sv ====
`timescale 1ns/100ps
module volsense_chk #(
  parameter logic [35:0] TARE_CYCLES = 36'h14
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire volsense_pkg::switch_type SWITCHES,
  input wire logic CELL_FAULT,
  input wire volsense_pkg::light_type LIGHTS,
  input wire logic [11:0] ANALOG_OUT_A
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  logic tare_on;
  logic [35:0] tare_cnt;
  // Only the tare shows a lit fault light with a zero output
  assign tare_on = LIGHTS.power && LIGHTS.fault && ANALOG_OUT_A == 12'h000;
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      tare_cnt <= 36'h0;
    end else begin
      tare_cnt <= tare_on ? tare_cnt + 36'h1 : 36'h0;
    end
  end
  ack_one_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  ack_after_a: assert property ((WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
    else $error("ack missing");
  unmapped_read_a: assert property ((WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_WE_I
    && WB_ADR_I == 8'h40) |=> WB_DAT_O == 32'h0) else $error("unmapped read not zero");
  fault_lights_a: assert property (CELL_FAULT [*4] |-> LIGHTS == 3'b101
    && ANALOG_OUT_A == 12'hFFF) else $error("fault indication wrong");
  warm_dark_a: assert property (!LIGHTS.power |-> LIGHTS == 3'b000
    && ANALOG_OUT_A == 12'h000) else $error("warm-up indication wrong");
  tare_start_a: assert property (($rose(SWITCHES.zero_capture_switch) && LIGHTS == 3'b110
    && !CELL_FAULT) |-> ##[1:4] tare_on) else $error("tare did not start");
  tare_end_a: assert property (($fell(LIGHTS.fault) && $past(ANALOG_OUT_A) == 12'h000
    && $past(LIGHTS.power)) |-> LIGHTS.power && LIGHTS.status) else $error("status not steady");
  tare_len_a: assert property ((!tare_on && tare_cnt != 36'h0 && LIGHTS.status)
    |-> tare_cnt + 36'h2 >= TARE_CYCLES && tare_cnt <= TARE_CYCLES + 36'h2)
    else $error("tare length wrong");
  cover property (tare_on);
  cover property (CELL_FAULT [*4] ##1 LIGHTS.fault);
  cover property (WB_ACK_O && WB_WE_I);
endmodule : volsense_chk

bind volume_sensor_ctrl volsense_chk #(.TARE_CYCLES(TARE_CYCLES)) i_chk (.REF_CLK, .RST,
  .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_DAT_O, .WB_ACK_O, .SWITCHES, .CELL_FAULT,
  .LIGHTS, .ANALOG_OUT_A);

// ==== bench/volume_sensor_ctrl_tb_top.sv ====
`timescale 1ns/100ps
module volume_sensor_ctrl_tb_top;
  logic ref_clk, rst, cyc, stb, we, ack, fault_cmd, cval, cflt, sval;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [15:0] press, raw, cp, sr;
  logic [11:0] out_a, out_b;
  volsense_pkg::switch_type sw_cmd, sw;
  volsense_pkg::light_type lights;
  int fail_count, checks;
  int pmid [4] = '{100, 250, 500, 1000};
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  volume_sensor_ctrl #(.TARE_CYCLES(36'h14), .WARMUP_CYCLES(36'hA), .FLASH_CYCLES(36'h4)) i_dut (
    .REF_CLK(ref_clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .SWITCHES(sw), .CELL_PRESSURE(cp), .CELL_VALID(cval), .CELL_FAULT(cflt), .SASH_RAW(sr),
    .SASH_VALID(sval), .LIGHTS(lights), .ANALOG_OUT_A(out_a), .ANALOG_OUT_B(out_b));
  installer_model i_far (.clk(ref_clk), .sw_cmd(sw_cmd), .press(press), .fault_cmd(fault_cmd),
    .raw(raw), .switches(sw), .cell_pressure(cp), .cell_valid(cval), .cell_fault(cflt),
    .sash_raw(sr), .sash_valid(sval));
  task results;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  task check_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val
  // Codes pass within two steps: gains are rounded fixed-point values
  task check_code(input logic [11:0] got, input logic [11:0] exp);
    int d;
    checks++;
    d = int'(got) - int'(exp);
    if ($isunknown(got) || d > 2 || d < -2) begin
      fail_count++;
      $display("wrong value at %0t: code %h expected %h", $time, got, exp);
    end
  endtask : check_code
  task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge ref_clk);
    while (ack !== 1'b1) begin
      @(posedge ref_clk);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge ref_clk);
  endtask : wb
  task wait_state(input logic [2:0] s);
    int n;
    n = 0;
    do begin
      wb(volsense_pkg::ADDR_STATUS, 1'b0, 32'h0);
      n++;
    end while (q[2:0] !== s && n < 200);
    check_val(32'(q[2:0]), 32'(s));
  endtask : wait_state
  task tare;
    sw_cmd.zero_capture_switch <= 1'b1;
    repeat (6) @(posedge ref_clk);
    check_val(32'({lights.fault, out_a}), 32'h1000);
    wait_state(3'h3);
    check_val(32'(lights), 32'h6);
    sw_cmd.zero_capture_switch <= 1'b0;
    wait_state(3'h4);
    check_val(32'(lights), 32'h6);
  endtask : tare
  task cal;
    raw <= 16'h0BB8;
    repeat (40) @(posedge ref_clk);
    wb(volsense_pkg::ADDR_CAL_WORK, 1'b1, 32'h1F4);
    raw <= 16'h05DC;
    repeat (40) @(posedge ref_clk);
    wb(volsense_pkg::ADDR_CAL_HALF, 1'b1, 32'hFA);
    raw <= 16'h0BB8;
    wb(volsense_pkg::ADDR_STATUS, 1'b0, 32'h0);
    check_val(32'(q[5:4]), 32'h2);
    repeat (300) @(posedge ref_clk);
  endtask : cal
  initial begin
    rst = 1'b1;
    {cyc, stb, we, fault_cmd} = 4'h0;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h0;
    sw_cmd = 4'h0;
    press = 16'h0;
    raw = 16'h0;
    fail_count = 0;
    checks = 0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    wb(volsense_pkg::ADDR_GAP, 1'b0, 32'h0);
    check_val(q, 32'h19);
    wb(volsense_pkg::ADDR_MAXVOL, 1'b0, 32'h0);
    check_val(q, 32'h3E8);
    wb(volsense_pkg::ADDR_WIDTH, 1'b1, 32'h2328);
    wb(volsense_pkg::ADDR_WIDTH, 1'b0, 32'h0);
    check_val(q, 32'h1B58);
    wb(volsense_pkg::ADDR_MAXVOL, 1'b1, 32'h0);
    wb(volsense_pkg::ADDR_MAXVOL, 1'b0, 32'h0);
    check_val(q, 32'h1);
    wb(volsense_pkg::ADDR_STATUS, 1'b0, 32'h0);
    check_val(32'(q[4]), 32'h1);
    wb(8'h40, 1'b0, 32'h0);
    check_val(q, 32'h0);
    wait_state(3'h1);
    check_code(out_a, 12'hFFF);
    press <= 16'h1E;
    tare();
    for (int r = 0; r < 4; r++) begin
      for (int l = 0; l < 2; l++) begin
        sw_cmd <= volsense_pkg::switch_type'({1'b0, l[0], r[1:0]});
        press <= 16'(30 + (l == 1 ? pmid[r] / 2 : pmid[r]));
        repeat (12) @(posedge ref_clk);
        check_code(out_a, l == 1 ? 12'h400 : 12'h800);
      end
    end
    sw_cmd <= 4'h0;
    press <= 16'h33E;
    repeat (12) @(posedge ref_clk);
    check_code(out_a, 12'hFFF);
    tare();
    fault_cmd <= 1'b1;
    repeat (6) @(posedge ref_clk);
    check_val(32'({lights, out_a}), 32'h5FFF);
    fault_cmd <= 1'b0;
    wb(volsense_pkg::ADDR_CTRL, 1'b1, 32'h1);
    wb(volsense_pkg::ADDR_WIDTH, 1'b1, 32'h4B0);
    wb(volsense_pkg::ADDR_MAXVOL, 1'b1, 32'h13B);
    check_code(out_b, 12'hFFF);
    cal();
    check_code(out_b, 12'hFFF);
    wb(volsense_pkg::ADDR_MAXVOL, 1'b1, 32'h276);
    cal();
    check_code(out_b, 12'h7FF);
    wb(volsense_pkg::ADDR_OUTPUT, 1'b0, 32'h0);
    check_val(q, 32'h01F407FF);
    raw <= 16'h02EE;
    repeat (300) @(posedge ref_clk);
    wb(volsense_pkg::ADDR_OUTPUT, 1'b0, 32'h0);
    check_val(q, 32'h007D0249);
    results();
  end
  // The tests take about 1300 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    results();
  end
endmodule : volume_sensor_ctrl_tb_top

// ==== inc/volsense_pkg.sv ====
package volsense_pkg;

  localparam longint CLK_HZ = 40_000_000;
  localparam int CNT_W = 36;

  // Times in their own units, cycle counts derived from the clock rate
  localparam longint TARE_S = 5;
  localparam longint WARMUP_S = 300;
  localparam longint FLASH_MS = 500;
  localparam longint TARE_CYC = TARE_S * CLK_HZ;
  localparam longint WARMUP_CYC = WARMUP_S * CLK_HZ;
  localparam longint FLASH_CYC = (FLASH_MS * CLK_HZ) / 1000;

  localparam int DAC_W = 12;
  localparam logic [11:0] DAC_FULL = 12'hFFF;
  localparam logic [11:0] DAC_ZERO = 12'h000;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_WIDTH = 8'h04;
  localparam logic [7:0] ADDR_GAP = 8'h08;
  localparam logic [7:0] ADDR_MAXVOL = 8'h0C;
  localparam logic [7:0] ADDR_CAL_WORK = 8'h10;
  localparam logic [7:0] ADDR_CAL_HALF = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_OUTPUT = 8'h1C;

  // Setting limits and values after reset
  localparam logic [12:0] WIDTH_RESET = 13'h04B0;
  localparam logic [12:0] WIDTH_MAX = 13'h1B58;
  localparam logic [9:0] GAP_RESET = 10'h019;
  localparam logic [9:0] GAP_MAX = 10'h3E8;
  localparam logic [9:0] MAXVOL_RESET = 10'h3E8;
  localparam logic [9:0] MAXVOL_MIN = 10'h001;
  localparam logic [9:0] MAXVOL_MAX = 10'h3E8;

  // Gains per range: 2^22/Pmid for the volume law, 2^23/Pmid for the pressure law
  localparam logic [16:0] VOL_GAIN [4] = '{17'h0A3D7, 17'h04189, 17'h020C5, 17'h01062};
  localparam logic [16:0] PRS_GAIN [4] = '{17'h147AE, 17'h08312, 17'h04189, 17'h020C5};

  typedef enum logic [2:0] {
    CELL_WARMUP = 3'b000,
    CELL_NEED_CAL = 3'b001,
    CELL_TARE = 3'b010,
    CELL_TARE_DONE = 3'b011,
    CELL_NORMAL = 3'b100,
    CELL_FAULT = 3'b101
  } cell_state_type;

  typedef enum logic [1:0] {
    SASH_IDLE = 2'b00,
    SASH_HEIGHT = 2'b01,
    SASH_VOLUME = 2'b10
  } sash_state_type;

  typedef struct packed {
    logic zero_capture_switch;
    logic output_law_select;
    logic range_select_high;
    logic range_select_low;
  } switch_type;

  typedef struct packed {
    logic power;
    logic status;
    logic fault;
  } light_type;

endpackage : volsense_pkg

// ==== rtl/seq_divider.sv ====
`timescale 1ns/100ps
module seq_divider #(
  parameter int NUM_W = 40,
  parameter int DEN_W = 24
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [NUM_W-1:0] num,
  input wire logic [DEN_W-1:0] den,
  output logic done,
  output logic [NUM_W-1:0] quot
);

  logic [DEN_W-1:0] rem;
  logic [7:0] cnt;
  logic busy;
  logic [DEN_W:0] shifted;

  assign shifted = {rem, quot[NUM_W-1]};

  // Restoring division, one quotient bit per clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rem <= '0;
      quot <= '0;
      cnt <= 8'h00;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (start) begin
      rem <= '0;
      quot <= num;
      cnt <= 8'(NUM_W);
      busy <= 1'b1;
      done <= 1'b0;
    end else if (busy) begin
      if (shifted >= {1'b0, den}) begin
        rem <= DEN_W'(shifted - {1'b0, den});
        quot <= {quot[NUM_W-2:0], 1'b1};
      end else begin
        rem <= shifted[DEN_W-1:0];
        quot <= {quot[NUM_W-2:0], 1'b0};
      end
      cnt <= cnt - 8'h01;
      busy <= (cnt != 8'h01);
      done <= (cnt == 8'h01);
    end else begin
      done <= 1'b0;
    end
  end

endmodule : seq_divider

// ==== rtl/volume_sensor_ctrl.sv ====
`timescale 1ns/100ps
module volume_sensor_ctrl #(
  parameter logic [35:0] TARE_CYCLES = 36'(volsense_pkg::TARE_CYC),
  parameter logic [35:0] WARMUP_CYCLES = 36'(volsense_pkg::WARMUP_CYC),
  parameter logic [35:0] FLASH_CYCLES = 36'(volsense_pkg::FLASH_CYC),
  parameter int FACE_VEL_MMS = 500
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire volsense_pkg::switch_type SWITCHES,
  input wire logic [15:0] CELL_PRESSURE,
  input wire logic CELL_VALID,
  input wire logic CELL_FAULT,
  input wire logic [15:0] SASH_RAW,
  input wire logic SASH_VALID,
  output volsense_pkg::light_type LIGHTS,
  output logic [11:0] ANALOG_OUT_A,
  output logic [11:0] ANALOG_OUT_B
);

  localparam logic [10:0] DEN_SCALE = 11'(1_000_000 / FACE_VEL_MMS);

  volsense_pkg::cell_state_type cell_state;
  volsense_pkg::sash_state_type sash_state;
  logic [35:0] timer;
  logic [35:0] flash_cnt;
  logic flash;
  logic zero_prev;
  logic [15:0] cell_last;
  logic [15:0] zero_ref;
  logic [11:0] cell_code;
  logic sash_mode;
  logic [12:0] sash_width;
  logic [9:0] sash_gap;
  logic [9:0] max_volume;
  logic [10:0] height_work;
  logic [10:0] height_half;
  logic [15:0] raw_work;
  logic [15:0] raw_half;
  logic [1:0] cal_points;
  logic sash_cal_needed;
  logic [15:0] sash_last;
  logic below;
  logic [10:0] height;
  logic [11:0] sash_code;
  logic div_start;
  logic [39:0] div_num;
  logic [23:0] div_den;
  logic div_done;
  logic [39:0] div_quot;
  logic wb_req;
  logic wb_wr;
  logic zero_rise;
  logic sash_ok;
  logic [1:0] range_idx;
  logic [15:0] p_net;
  logic [32:0] vol_x;
  logic [32:0] prs_x;
  logic [12:0] vol_root;
  logic [11:0] next_cell_code;
  logic [11:0] next_height;
  logic [24:0] area;
  logic [31:0] wr_old;
  logic [31:0] wr_val;
  logic [15:0] raw_dist;
  logic [10:0] height_span;

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = dat[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  function automatic logic [12:0] isqrt(input logic [23:0] v);
    logic [12:0] root;
    logic [12:0] cand;
    root = 13'h0000;
    for (int i = 12; i >= 0; i--) begin
      cand = root | 13'(1 << i);
      if ({13'h0000, cand} * {13'h0000, cand} <= {2'b00, v}) begin
        root = cand;
      end
    end
    return root;
  endfunction : isqrt

  assign wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wb_wr = wb_req & WB_WE_I;
  assign zero_rise = SWITCHES.zero_capture_switch & ~zero_prev;
  assign sash_ok = (raw_work > raw_half) && (height_work > height_half);
  // Smaller value subtracted from the larger, so the cast never hides a lost carry
  assign raw_dist = (SASH_RAW < raw_half) ? 16'(raw_half - SASH_RAW) : 16'(SASH_RAW - raw_half);
  assign height_span = 11'(height_work - height_half);

  // Pressure range decode
  assign range_idx = {SWITCHES.range_select_high, SWITCHES.range_select_low};
  assign p_net = (CELL_PRESSURE > zero_ref) ? 16'(CELL_PRESSURE - zero_ref) : 16'h0000;
  assign vol_x = {1'b0, p_net} * volsense_pkg::VOL_GAIN[range_idx];
  assign prs_x = {1'b0, p_net} * volsense_pkg::PRS_GAIN[range_idx];
  // Saturating before the root keeps 4x mid-scale pressure at exactly full scale
  assign vol_root = isqrt((vol_x[32:24] != 9'h000) ? 24'hFFFFFF : vol_x[23:0]);

  always_comb begin
    if (SWITCHES.output_law_select) begin
      next_cell_code = (prs_x[32:24] != 9'h000) ? volsense_pkg::DAC_FULL : prs_x[23:12];
    end else begin
      next_cell_code = vol_root[12] ? volsense_pkg::DAC_FULL : vol_root[11:0];
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      cell_last <= 16'h0000;
      cell_code <= 12'h000;
      zero_prev <= 1'b0;
    end else begin
      zero_prev <= SWITCHES.zero_capture_switch;
      if (CELL_VALID) begin
        cell_last <= CELL_PRESSURE;
        cell_code <= next_cell_code;
      end
    end
  end

  // Flash timebase, free running
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      flash_cnt <= 36'h000000000;
      flash <= 1'b0;
    end else if (flash_cnt >= FLASH_CYCLES - 36'h000000001) begin
      flash_cnt <= 36'h000000000;
      flash <= ~flash;
    end else begin
      flash_cnt <= flash_cnt + 36'h000000001;
    end
  end

  // Cell state sequence; a cell fault overrides everything
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      cell_state <= volsense_pkg::CELL_WARMUP;
      timer <= 36'h000000000;
      zero_ref <= 16'h0000;
    end else if (CELL_FAULT) begin
      cell_state <= volsense_pkg::CELL_FAULT;
      timer <= 36'h000000000;
    end else begin
      timer <= timer + 36'h000000001;
      unique case (cell_state)
        volsense_pkg::CELL_WARMUP: begin
          if (timer >= WARMUP_CYCLES - 36'h000000001) begin
            cell_state <= volsense_pkg::CELL_NEED_CAL;
            timer <= 36'h000000000;
          end
        end
        volsense_pkg::CELL_NEED_CAL, volsense_pkg::CELL_NORMAL: begin
          if (zero_rise) begin
            cell_state <= volsense_pkg::CELL_TARE;
            timer <= 36'h000000000;
          end
        end
        volsense_pkg::CELL_TARE: begin
          if (timer >= TARE_CYCLES - 36'h000000001) begin
            zero_ref <= cell_last;
            cell_state <= volsense_pkg::CELL_TARE_DONE;
          end
        end
        volsense_pkg::CELL_TARE_DONE: begin
          if (!SWITCHES.zero_capture_switch) begin
            cell_state <= volsense_pkg::CELL_NORMAL;
          end
        end
        volsense_pkg::CELL_FAULT: begin
          cell_state <= volsense_pkg::CELL_NEED_CAL;
          timer <= 36'h000000000;
        end
        default: begin
          cell_state <= volsense_pkg::CELL_WARMUP;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      LIGHTS <= '0;
      ANALOG_OUT_A <= volsense_pkg::DAC_ZERO;
    end else begin
      unique case (cell_state)
        volsense_pkg::CELL_FAULT: begin
          LIGHTS <= '{power: 1'b1, status: 1'b0, fault: 1'b1};
          ANALOG_OUT_A <= volsense_pkg::DAC_FULL;
        end
        volsense_pkg::CELL_NEED_CAL: begin
          LIGHTS <= '{power: 1'b1, status: flash, fault: flash};
          ANALOG_OUT_A <= volsense_pkg::DAC_FULL;
        end
        volsense_pkg::CELL_TARE: begin
          LIGHTS <= '{power: 1'b1, status: flash, fault: 1'b1};
          ANALOG_OUT_A <= volsense_pkg::DAC_ZERO;
        end
        volsense_pkg::CELL_TARE_DONE: begin
          LIGHTS <= '{power: 1'b1, status: 1'b1, fault: 1'b0};
          ANALOG_OUT_A <= volsense_pkg::DAC_ZERO;
        end
        volsense_pkg::CELL_NORMAL: begin
          LIGHTS <= '{power: 1'b1, status: 1'b1, fault: 1'b0};
          ANALOG_OUT_A <= cell_code;
        end
        default: begin
          LIGHTS <= '{power: flash, status: 1'b0, fault: 1'b0};
          ANALOG_OUT_A <= volsense_pkg::DAC_ZERO;
        end
      endcase
    end
  end

  // Output B repeats the cell output unless sash mode is selected
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ANALOG_OUT_B <= volsense_pkg::DAC_ZERO;
    end else if (!sash_mode) begin
      ANALOG_OUT_B <= ANALOG_OUT_A;
    end else if (sash_cal_needed || !sash_ok) begin
      ANALOG_OUT_B <= volsense_pkg::DAC_FULL;
    end else begin
      ANALOG_OUT_B <= sash_code;
    end
  end

  // Current field under the write address, so byte lanes merge into it
  always_comb begin
    unique case (WB_ADR_I)
      volsense_pkg::ADDR_CTRL: wr_old = {31'h00000000, sash_mode};
      volsense_pkg::ADDR_WIDTH: wr_old = {19'h00000, sash_width};
      volsense_pkg::ADDR_GAP: wr_old = {22'h000000, sash_gap};
      volsense_pkg::ADDR_MAXVOL: wr_old = {22'h000000, max_volume};
      volsense_pkg::ADDR_CAL_WORK: wr_old = {21'h000000, height_work};
      volsense_pkg::ADDR_CAL_HALF: wr_old = {21'h000000, height_half};
      default: wr_old = 32'h00000000;
    endcase
    wr_val = merge(wr_old, WB_DAT_I, WB_SEL_I);
  end

  // Settings and calibration points
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      sash_mode <= 1'b0;
      sash_width <= volsense_pkg::WIDTH_RESET;
      sash_gap <= volsense_pkg::GAP_RESET;
      max_volume <= volsense_pkg::MAXVOL_RESET;
      height_work <= 11'h000;
      height_half <= 11'h000;
      raw_work <= 16'h0000;
      raw_half <= 16'h0000;
      cal_points <= 2'b00;
      sash_cal_needed <= 1'b1;
    end else if (wb_wr) begin
      unique case (WB_ADR_I)
        volsense_pkg::ADDR_CTRL: begin
          sash_mode <= wr_val[0];
        end
        volsense_pkg::ADDR_WIDTH: begin
          sash_width <= (wr_val > 32'(volsense_pkg::WIDTH_MAX)) ? volsense_pkg::WIDTH_MAX :
                        wr_val[12:0];
          sash_cal_needed <= 1'b1;
          cal_points <= 2'b00;
        end
        volsense_pkg::ADDR_GAP: begin
          sash_gap <= (wr_val > 32'(volsense_pkg::GAP_MAX)) ? volsense_pkg::GAP_MAX :
                      wr_val[9:0];
          sash_cal_needed <= 1'b1;
          cal_points <= 2'b00;
        end
        volsense_pkg::ADDR_MAXVOL: begin
          max_volume <= (wr_val > 32'(volsense_pkg::MAXVOL_MAX)) ? volsense_pkg::MAXVOL_MAX :
                        (wr_val < 32'(volsense_pkg::MAXVOL_MIN)) ? volsense_pkg::MAXVOL_MIN :
                        wr_val[9:0];
          sash_cal_needed <= 1'b1;
          cal_points <= 2'b00;
        end
        volsense_pkg::ADDR_CAL_WORK: begin
          height_work <= wr_val[10:0];
          raw_work <= sash_last;
          cal_points <= cal_points | 2'b01;
          sash_cal_needed <= ~cal_points[1];
        end
        volsense_pkg::ADDR_CAL_HALF: begin
          height_half <= wr_val[10:0];
          raw_half <= sash_last;
          cal_points <= cal_points | 2'b10;
          sash_cal_needed <= ~cal_points[0];
        end
        default: begin
        end
      endcase
    end
  end

  // Sash height then volume, both through the shared divider
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      sash_state <= volsense_pkg::SASH_IDLE;
      sash_last <= 16'h0000;
      below <= 1'b0;
      height <= 11'h000;
      sash_code <= 12'h000;
      div_start <= 1'b0;
      div_num <= 40'h0000000000;
      div_den <= 24'h000001;
    end else begin
      div_start <= 1'b0;
      if (SASH_VALID) begin
        sash_last <= SASH_RAW;
      end
      unique case (sash_state)
        volsense_pkg::SASH_IDLE: begin
          if (SASH_VALID && sash_ok) begin
            below <= SASH_RAW < raw_half;
            div_num <= {24'h000000, raw_dist} * {29'h00000000, height_span};
            div_den <= 24'(raw_work - raw_half);
            div_start <= 1'b1;
            sash_state <= volsense_pkg::SASH_HEIGHT;
          end
        end
        volsense_pkg::SASH_HEIGHT: begin
          if (div_done) begin
            height <= next_height[10:0];
            div_num <= {15'h0000, area} * 40'h0000000FFF;
            div_den <= {14'h0000, max_volume} * {13'h0000, DEN_SCALE};
            div_start <= 1'b1;
            sash_state <= volsense_pkg::SASH_VOLUME;
          end
        end
        volsense_pkg::SASH_VOLUME: begin
          if (div_done) begin
            sash_code <= (div_quot > 40'h0000000FFF) ? volsense_pkg::DAC_FULL : div_quot[11:0];
            sash_state <= volsense_pkg::SASH_IDLE;
          end
        end
        default: begin
          sash_state <= volsense_pkg::SASH_IDLE;
        end
      endcase
    end
  end

  // Height saturates at zero and at the field maximum
  always_comb begin
    if (below) begin
      next_height = (div_quot > 40'(height_half)) ? 12'h000 : 12'(height_half - div_quot[10:0]);
    end else if (div_quot > 40'h00000007FF) begin
      next_height = 12'h7FF;
    end else begin
      next_height = {1'b0, height_half} + {1'b0, div_quot[10:0]};
    end
    if (next_height > 12'h7FF) begin
      next_height = 12'h7FF;
    end
    area = ({14'h0000, next_height[10:0]} + {15'h0000, sash_gap}) * {12'h000, sash_width};
  end

  seq_divider #(
    .NUM_W(40),
    .DEN_W(24)
  ) u_div (
    .clk(REF_CLK),
    .rst(RST),
    .start(div_start),
    .num(div_num),
    .den(div_den),
    .done(div_done),
    .quot(div_quot)
  );

  // Wishbone classic slave, one wait state, unmapped reads as zero
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end else begin
      WB_ACK_O <= wb_req;
      if (wb_req && !WB_WE_I) begin
        unique case (WB_ADR_I)
          volsense_pkg::ADDR_CTRL: WB_DAT_O <= {31'h00000000, sash_mode};
          volsense_pkg::ADDR_WIDTH: WB_DAT_O <= {19'h00000, sash_width};
          volsense_pkg::ADDR_GAP: WB_DAT_O <= {22'h000000, sash_gap};
          volsense_pkg::ADDR_MAXVOL: WB_DAT_O <= {22'h000000, max_volume};
          volsense_pkg::ADDR_CAL_WORK: WB_DAT_O <= {raw_work, 5'h00, height_work};
          volsense_pkg::ADDR_CAL_HALF: WB_DAT_O <= {raw_half, 5'h00, height_half};
          volsense_pkg::ADDR_STATUS: WB_DAT_O <= {16'h0000, 1'b0, LIGHTS, SWITCHES,
                                                  2'b00, sash_ok, sash_cal_needed,
                                                  1'b0, cell_state};
          volsense_pkg::ADDR_OUTPUT: WB_DAT_O <= {5'h00, height, 4'h0, ANALOG_OUT_B};
          default: WB_DAT_O <= 32'h00000000;
        endcase
      end
    end
  end

endmodule : volume_sensor_ctrl
